// file: verilog/exec_pkg.sv
// Package with register map, instruction layout and constants of the execution datapath
package exec_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int MEM_AW = 8;
   localparam int NUM_PTR = 2;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] INSTR_OFS = 6'h00;
   localparam logic [ADDR_W-1:0] WREG_OFS = 6'h04;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 6'h08;
   localparam logic [ADDR_W-1:0] BANK_OFS = 6'h0c;
   localparam logic [ADDR_W-1:0] LATCH_OFS = 6'h10;
   localparam logic [ADDR_W-1:0] PTR0_OFS = 6'h14;
   localparam logic [ADDR_W-1:0] PTR1_OFS = 6'h18;
   localparam logic [ADDR_W-1:0] MADDR_OFS = 6'h1c;
   localparam logic [ADDR_W-1:0] MDATA_OFS = 6'h20;

   // Operation codes
   localparam logic [2:0] OP_LSR = 3'h0;
   localparam logic [2:0] OP_FMOVE = 3'h1;
   localparam logic [2:0] OP_ILOAD = 3'h2;
   localparam logic [2:0] OP_BANK = 3'h3;
   localparam logic [2:0] OP_LATCH = 3'h4;
   localparam logic [2:0] OP_WLIT = 3'h5;

   // Pointer update modes
   localparam logic [1:0] MODE_PREINC = 2'h0;
   localparam logic [1:0] MODE_PREDEC = 2'h1;
   localparam logic [1:0] MODE_POSTINC = 2'h2;
   localparam logic [1:0] MODE_POSTDEC = 2'h3;

   // File addresses of the indirect data ports
   localparam logic [6:0] IND0_FADDR = 7'h00;
   localparam logic [6:0] IND1_FADDR = 7'h01;

   // Status field positions
   localparam int ST_CARRY = 0;
   localparam int ST_ZERO = 1;
   localparam int ST_BUSY = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [7:0] WREG_RST = 8'h00;
   localparam logic [4:0] BANK_RST = 5'h00;
   localparam logic [6:0] LATCH_RST = 7'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [15:0] PTR_ONE = 16'h0001;
   localparam logic [MEM_AW-1:0] MADDR_RST = 8'h00;

   typedef struct packed {
      logic [8:0] unused;
      logic [6:0] faddr;
      logic [7:0] lit;
      logic rel;
      logic ptr_sel;
      logic [1:0] pointer_update_mode_field;
      logic dest;
      logic [2:0] op;
   } instr_t;
endpackage : exec_pkg

// file: verilog/data_mem.sv
// Byte-wide data memory with one write port and a registered read port
`timescale 1ns/10ps
module data_mem #(
   parameter int AW = 8
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge aclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : data_mem

// file: verilog/shift_move_literal_exec.sv
// Execution datapath for shift, file move, indirect load and literal loads with an AXI4-Lite register port
// Summary of operation
// - The right shift moves every bit one place down, puts zero in bit seven and old bit zero in carry.
// - A right shift with destination zero writes the working register, with one writes the source file register.
// - The file move copies the file register to the working register on destination zero, else rewrites it.
// - The file move updates the zero flag from the moved value in both destinations.
// - The indirect load takes its address by mode 00 pre-increment, 01 pre-decrement, 10/11 post-inc/dec.
// - The relative indirect load reads at pointer plus a signed offset of -32..31 and keeps the pointer.
// - The indirect data port has no storage; access to it reaches the address the selected pointer holds.
// - The pointers span 0000h..FFFFh and wrap at both ends.
// - The bank literal load sets the bank select register and leaves the flags alone.
// - The latch literal load sets the seven-bit program counter high latch and leaves the flags alone.
// - The working literal load sets the working register in one cycle and leaves the flags alone.
`timescale 1ns/10ps
module shift_move_literal_exec (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [exec_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [exec_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [exec_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [exec_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} state_t;

   state_t state_q;
   exec_pkg::instr_t instr_q;
   logic [exec_pkg::ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [7:0] w_q;
   logic c_q;
   logic z_q;
   logic [4:0] bank_select_reg;
   logic [6:0] program_counter_high_latch;
   logic [15:0] indirect_pointer [exec_pkg::NUM_PTR];
   logic [15:0] ea_q;
   logic [exec_pkg::MEM_AW-1:0] maddr_q;
   logic [7:0] mem_rdata;

   // Byte-lane merge keeps unstrobed lanes of the old value
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Bus write is performed only when idle so software never collides with an executing instruction
   wire busy = (state_q != ST_IDLE);
   wire wr_go = !awready && !wready && !bvalid && !busy;
   wire wsel_instr = wr_go && (awaddr_q == exec_pkg::INSTR_OFS);
   wire wsel_w = wr_go && (awaddr_q == exec_pkg::WREG_OFS);
   wire wsel_st = wr_go && (awaddr_q == exec_pkg::STATUS_OFS);
   wire wsel_bank = wr_go && (awaddr_q == exec_pkg::BANK_OFS);
   wire wsel_latch = wr_go && (awaddr_q == exec_pkg::LATCH_OFS);
   wire wsel_maddr = wr_go && (awaddr_q == exec_pkg::MADDR_OFS);
   wire wsel_mdata = wr_go && (awaddr_q == exec_pkg::MDATA_OFS);
   wire [exec_pkg::NUM_PTR-1:0] wsel_ptr = {wr_go && (awaddr_q == exec_pkg::PTR1_OFS),
                                           wr_go && (awaddr_q == exec_pkg::PTR0_OFS)};
   wire w_mapped = wsel_instr | wsel_w | wsel_st | wsel_bank | wsel_latch | wsel_maddr | wsel_mdata | (|wsel_ptr);
   wire [31:0] wmerged = merge(32'h0000_0000, wdata_q, wstrb_q);

   // Instruction decode at issue
   exec_pkg::instr_t ins;
   assign ins = exec_pkg::instr_t'(merge(instr_q, wdata_q, wstrb_q));
   wire is_ind = (ins.op == exec_pkg::OP_ILOAD);
   wire is_file = (ins.op == exec_pkg::OP_LSR) || (ins.op == exec_pkg::OP_FMOVE);
   wire start = wsel_instr && (is_ind || is_file);
   wire lit_bank = wsel_instr && (ins.op == exec_pkg::OP_BANK);
   wire lit_latch = wsel_instr && (ins.op == exec_pkg::OP_LATCH);
   wire lit_w = wsel_instr && (ins.op == exec_pkg::OP_WLIT);
   wire f_ind0 = (ins.faddr == exec_pkg::IND0_FADDR);
   wire f_ind1 = (ins.faddr == exec_pkg::IND1_FADDR);
   wire psel = is_ind ? ins.ptr_sel : f_ind1;
   wire [15:0] pval = indirect_pointer[psel];
   wire [15:0] p_inc = pval + exec_pkg::PTR_ONE;
   wire [15:0] p_dec = pval - exec_pkg::PTR_ONE;
   wire [15:0] p_off = pval + {{10{ins.lit[5]}}, ins.lit[5:0]};
   wire [1:0] mode = ins.pointer_update_mode_field;
   wire [15:0] ea_ind = ins.rel ? p_off :
                        (mode == exec_pkg::MODE_PREINC) ? p_inc :
                        (mode == exec_pkg::MODE_PREDEC) ? p_dec : pval;
   // The indirect data port is only an alias of the pointed-to location
   wire [15:0] ea_file = (f_ind0 || f_ind1) ? pval : {9'h000, ins.faddr};
   wire [15:0] ptr_next = (mode == exec_pkg::MODE_PREDEC || mode == exec_pkg::MODE_POSTDEC) ? p_dec : p_inc;
   wire ptr_step = start && is_ind && !ins.rel;

   // Execution of the latched instruction with the memory byte in hand
   wire exec = (state_q == ST_EXEC);
   wire op_lsr = (instr_q.op == exec_pkg::OP_LSR);
   wire op_ind = (instr_q.op == exec_pkg::OP_ILOAD);
   wire [7:0] result = op_lsr ? {1'b0, mem_rdata[7:1]} : mem_rdata;
   wire exec_w_we = exec && (op_ind || !instr_q.dest);
   wire exec_mem_we = exec && !op_ind && instr_q.dest;
   wire mem_we = exec_mem_we || wsel_mdata;
   wire [exec_pkg::MEM_AW-1:0] mem_waddr = busy ? ea_q[exec_pkg::MEM_AW-1:0] : maddr_q;
   wire [7:0] mem_wdata = busy ? result : wmerged[7:0];

   data_mem #(.AW(exec_pkg::MEM_AW)) u_mem (
      .aclk(aclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(ea_q[exec_pkg::MEM_AW-1:0]),
      .rdata(mem_rdata)
   );

   // Read decode
   wire [2:0] status_v = {busy, z_q, c_q};
   wire r_mapped = (araddr == exec_pkg::INSTR_OFS) || (araddr == exec_pkg::WREG_OFS) ||
                   (araddr == exec_pkg::STATUS_OFS) || (araddr == exec_pkg::BANK_OFS) ||
                   (araddr == exec_pkg::LATCH_OFS) || (araddr == exec_pkg::PTR0_OFS) ||
                   (araddr == exec_pkg::PTR1_OFS) || (araddr == exec_pkg::MADDR_OFS) ||
                   (araddr == exec_pkg::MDATA_OFS);
   wire [31:0] rd_mux = (araddr == exec_pkg::INSTR_OFS) ? instr_q :
                        (araddr == exec_pkg::WREG_OFS) ? {24'h000000, w_q} :
                        (araddr == exec_pkg::STATUS_OFS) ? {29'h00000000, status_v} :
                        (araddr == exec_pkg::BANK_OFS) ? {27'h0000000, bank_select_reg} :
                        (araddr == exec_pkg::LATCH_OFS) ? {25'h0000000, program_counter_high_latch} :
                        (araddr == exec_pkg::PTR0_OFS) ? {16'h0000, indirect_pointer[0]} :
                        (araddr == exec_pkg::PTR1_OFS) ? {16'h0000, indirect_pointer[1]} :
                        (araddr == exec_pkg::MADDR_OFS) ? {24'h000000, maddr_q} : 32'h0000_0000;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= exec_pkg::RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awready <= 1'b0;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_go)
         begin
            bvalid <= 1'b1;
            bresp <= w_mapped ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= exec_pkg::RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= r_mapped ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ST_IDLE;
         instr_q <= '0;
         ea_q <= exec_pkg::PTR_RST;
      end
      else
      begin
         if (wsel_instr)
         begin
            instr_q <= ins;
         end
         if (start)
         begin
            ea_q <= is_ind ? ea_ind : ea_file;
         end
         else if (wsel_maddr)
         begin
            ea_q <= {8'h00, wmerged[exec_pkg::MEM_AW-1:0]};
         end
         case (state_q)
            ST_IDLE: state_q <= start ? ST_READ : ST_IDLE;
            ST_READ: state_q <= ST_EXEC;
            ST_EXEC: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_q <= exec_pkg::WREG_RST;
         c_q <= 1'b0;
         z_q <= 1'b0;
         bank_select_reg <= exec_pkg::BANK_RST;
         program_counter_high_latch <= exec_pkg::LATCH_RST;
         maddr_q <= exec_pkg::MADDR_RST;
      end
      else
      begin
         if (exec_w_we)
            w_q <= result;
         else if (lit_w)
            w_q <= ins.lit;
         else if (wsel_w)
            w_q <= wmerged[7:0];
         if (exec)
            z_q <= (result == 8'h00);
         else if (wsel_st)
            z_q <= wmerged[exec_pkg::ST_ZERO];
         if (exec && op_lsr)
            c_q <= mem_rdata[0];
         else if (wsel_st)
            c_q <= wmerged[exec_pkg::ST_CARRY];
         if (lit_bank)
            bank_select_reg <= ins.lit[4:0];
         else if (wsel_bank)
            bank_select_reg <= wmerged[4:0];
         if (lit_latch)
            program_counter_high_latch <= ins.lit[6:0];
         else if (wsel_latch)
            program_counter_high_latch <= wmerged[6:0];
         if (wsel_maddr)
            maddr_q <= wmerged[exec_pkg::MEM_AW-1:0];
      end
   end

   for (genvar gi = 0; gi < exec_pkg::NUM_PTR; gi++)
   begin : g_ptr
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            indirect_pointer[gi] <= exec_pkg::PTR_RST;
         else if (ptr_step && (psel == gi))
            indirect_pointer[gi] <= ptr_next;
         else if (wsel_ptr[gi])
            indirect_pointer[gi] <= wmerged[15:0];
      end
   end

   wire rd_bit0 = mem_rdata[0];

   AST_LSR_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
      exec && op_lsr && !instr_q.dest |=> (w_q == ($past(mem_rdata) >> 1)) && (c_q == $past(rd_bit0)))
      else $error("right shift result or carry wrong");
   AST_LSR_DEST: assert property (@(posedge aclk) disable iff (!aresetn)
      exec && op_lsr && instr_q.dest |-> mem_we && (mem_wdata == {1'b0, mem_rdata[7:1]}) ##1 $stable(w_q))
      else $error("right shift written to wrong destination");
   AST_FMOVE_W: assert property (@(posedge aclk) disable iff (!aresetn)
      start && (ins.op == exec_pkg::OP_FMOVE) && !ins.dest |=> ##1 exec ##1 (w_q == $past(mem_rdata)))
      else $error("file move did not reach working register");
   AST_FMOVE_Z: assert property (@(posedge aclk) disable iff (!aresetn)
      exec && (instr_q.op == exec_pkg::OP_FMOVE) |=> (z_q == ($past(mem_rdata) == 8'h00)))
      else $error("file move zero flag wrong");
   AST_PREINC: assert property (@(posedge aclk) disable iff (!aresetn)
      start && is_ind && !ins.rel && (mode == exec_pkg::MODE_PREINC) && !ins.ptr_sel
      |=> (indirect_pointer[0] == $past(p_inc)) && (ea_q == indirect_pointer[0]))
      else $error("pre-increment address wrong");
   AST_POSTDEC: assert property (@(posedge aclk) disable iff (!aresetn)
      start && is_ind && !ins.rel && (mode == exec_pkg::MODE_POSTDEC) && ins.ptr_sel
      |=> (ea_q == $past(pval)) && (indirect_pointer[1] == ea_q - exec_pkg::PTR_ONE))
      else $error("post-decrement address wrong");
   AST_REL: assert property (@(posedge aclk) disable iff (!aresetn)
      start && is_ind && ins.rel |=> (ea_q == $past(p_off)) && $stable(indirect_pointer[0])
      && $stable(indirect_pointer[1]))
      else $error("relative load moved pointer or used wrong address");
   AST_ALIAS: assert property (@(posedge aclk) disable iff (!aresetn)
      start && is_file && (f_ind0 || f_ind1) |=> (ea_q == indirect_pointer[$past(f_ind1)]))
      else $error("indirect port not aliased to pointer");
   AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
      ptr_step && (pval == 16'hffff) && !mode[0] |=> (indirect_pointer[$past(psel)] == 16'h0000))
      else $error("pointer did not wrap");
   AST_BANK: assert property (@(posedge aclk) disable iff (!aresetn)
      lit_bank |=> (bank_select_reg == $past(ins.lit[4:0])) && $stable(z_q) && $stable(c_q))
      else $error("bank literal load wrong");
   AST_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      lit_latch |=> (program_counter_high_latch == $past(ins.lit[6:0])) && $stable(z_q))
      else $error("latch literal load wrong");
   AST_WLIT: assert property (@(posedge aclk) disable iff (!aresetn)
      lit_w |=> (w_q == $past(ins.lit)) && !busy && $stable(c_q) && $stable(z_q))
      else $error("working literal load wrong");
   AST_ILOAD_Z: assert property (@(posedge aclk) disable iff (!aresetn)
      exec && op_ind |=> (z_q == (w_q == 8'h00)))
      else $error("indirect load zero flag wrong");
endmodule : shift_move_literal_exec

// file: tb/shift_move_literal_exec_tb_top.sv
// Self-checking bench that runs the execution datapath through its AXI4-Lite register port
`timescale 1ns/10ps
`define CHK(got, exp) \
begin \
   num_checks++; \
   if ((got) !== (exp)) \
   begin \
      fails++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); \
   end \
end
module shift_move_literal_exec_tb_top;
   logic aclk;
   logic aresetn;
   logic [exec_pkg::ADDR_W-1:0] awaddr;
   logic [exec_pkg::ADDR_W-1:0] araddr;
   logic [2:0] awprot;
   logic [2:0] arprot;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [exec_pkg::DATA_W-1:0] wdata;
   logic [exec_pkg::DATA_W-1:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   logic [31:0] d;
   logic [1:0] r;
   logic [7:0] exp_w [4] = '{8'h33, 8'h11, 8'h22, 8'h22};
   logic [31:0] exp_p [4] = '{32'h51, 32'h4f, 32'h51, 32'h4f};
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;

   shift_move_literal_exec dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         results();
      end
   end

   // Both channels offered together; each released on its own handshake, bready held until bvalid
   task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            resp = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : wr

   task automatic get(input logic [5:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            v = rdata;
            resp = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : get

   task automatic put(input logic [5:0] a, input logic [31:0] v);
      logic [1:0] resp;
      wr(a, v, resp);
      `CHK(resp, exec_pkg::RESP_OKAY)
   endtask : put

   task automatic expect_reg(input logic [5:0] a, input logic [31:0] v);
      logic [31:0] got;
      logic [1:0] resp;
      get(a, got, resp);
      `CHK(got, v)
      `CHK(resp, exec_pkg::RESP_OKAY)
   endtask : expect_reg

   task automatic mem_set(input logic [7:0] a, input logic [7:0] v);
      put(exec_pkg::MADDR_OFS, {24'h0, a});
      put(exec_pkg::MDATA_OFS, {24'h0, v});
   endtask : mem_set

   function automatic logic [31:0] mk(logic [2:0] op, logic dst, logic [1:0] m, logic sel, logic rl,
      logic [7:0] k, logic [6:0] f);
      exec_pkg::instr_t t;
      t = '{unused: 9'h0, faddr: f, lit: k, rel: rl, ptr_sel: sel, pointer_update_mode_field: m, dest: dst, op: op};
      return t;
   endfunction : mk

   // Polls busy a bounded number of times so a stuck flag shows as a result mismatch
   task automatic exec(input logic [31:0] instr);
      logic [31:0] st;
      logic [1:0] resp;
      put(exec_pkg::INSTR_OFS, instr);
      st = 32'h4;
      for (int n = 0; n < 8 && st[exec_pkg::ST_BUSY] !== 1'b0; n++)
         get(exec_pkg::STATUS_OFS, st, resp);
   endtask : exec

   initial
   begin
      aresetn = 1'b0;
      awaddr = '0;
      araddr = '0;
      awprot = 3'h0;
      arprot = 3'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      wdata = '0;
      wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 9; i++)
         expect_reg(6'(i * 4), 32'h0);
      get(6'h24, d, r);
      `CHK(r, exec_pkg::RESP_SLVERR)
      `CHK(d, 32'h0)
      wr(6'h3c, 32'hffff_ffff, r);
      `CHK(r, exec_pkg::RESP_SLVERR)
      // Literal loads with both flags preset, which must survive
      put(exec_pkg::STATUS_OFS, 32'h3);
      exec(mk(exec_pkg::OP_WLIT, 1'b0, 2'h0, 1'b0, 1'b0, 8'h5a, 7'h0));
      expect_reg(exec_pkg::WREG_OFS, 32'h5a);
      expect_reg(exec_pkg::STATUS_OFS, 32'h3);
      exec(mk(exec_pkg::OP_BANK, 1'b0, 2'h0, 1'b0, 1'b0, 8'h0f, 7'h0));
      expect_reg(exec_pkg::BANK_OFS, 32'h0f);
      expect_reg(exec_pkg::STATUS_OFS, 32'h3);
      exec(mk(exec_pkg::OP_LATCH, 1'b0, 2'h0, 1'b0, 1'b0, 8'h7f, 7'h0));
      expect_reg(exec_pkg::LATCH_OFS, 32'h7f);
      expect_reg(exec_pkg::STATUS_OFS, 32'h3);
      // Right shift into the working register, then back into the file
      mem_set(8'h40, 8'h81);
      exec(mk(exec_pkg::OP_LSR, 1'b0, 2'h0, 1'b0, 1'b0, 8'h0, 7'h40));
      expect_reg(exec_pkg::WREG_OFS, 32'h40);
      expect_reg(exec_pkg::STATUS_OFS, 32'h1);
      mem_set(8'h41, 8'h01);
      exec(mk(exec_pkg::OP_LSR, 1'b1, 2'h0, 1'b0, 1'b0, 8'h0, 7'h41));
      expect_reg(exec_pkg::WREG_OFS, 32'h40);
      expect_reg(exec_pkg::STATUS_OFS, 32'h3);
      exec(mk(exec_pkg::OP_FMOVE, 1'b0, 2'h0, 1'b0, 1'b0, 8'h0, 7'h41));
      expect_reg(exec_pkg::WREG_OFS, 32'h0);
      exec(mk(exec_pkg::OP_FMOVE, 1'b0, 2'h0, 1'b0, 1'b0, 8'h0, 7'h40));
      expect_reg(exec_pkg::WREG_OFS, 32'h81);
      expect_reg(exec_pkg::STATUS_OFS, 32'h1);
      // File move onto itself only tests the value
      mem_set(8'h42, 8'h00);
      put(exec_pkg::WREG_OFS, 32'h33);
      exec(mk(exec_pkg::OP_FMOVE, 1'b1, 2'h0, 1'b0, 1'b0, 8'h0, 7'h42));
      expect_reg(exec_pkg::WREG_OFS, 32'h33);
      expect_reg(exec_pkg::STATUS_OFS, 32'h3);
      // All four pointer update modes from the same start
      mem_set(8'h4f, 8'h11);
      mem_set(8'h50, 8'h22);
      mem_set(8'h51, 8'h33);
      for (int m = 0; m < 4; m++)
      begin
         put(exec_pkg::PTR0_OFS, 32'h50);
         exec(mk(exec_pkg::OP_ILOAD, 1'b0, 2'(m), 1'b0, 1'b0, 8'h0, 7'h0));
         expect_reg(exec_pkg::WREG_OFS, {24'h0, exp_w[m]});
         expect_reg(exec_pkg::PTR0_OFS, exp_p[m]);
         expect_reg(exec_pkg::STATUS_OFS, 32'h1);
      end
      // Wrap at both ends of the pointer range
      mem_set(8'h00, 8'h00);
      put(exec_pkg::PTR1_OFS, 32'hffff);
      exec(mk(exec_pkg::OP_ILOAD, 1'b0, exec_pkg::MODE_PREINC, 1'b1, 1'b0, 8'h0, 7'h0));
      expect_reg(exec_pkg::PTR1_OFS, 32'h0);
      expect_reg(exec_pkg::STATUS_OFS, 32'h3);
      exec(mk(exec_pkg::OP_ILOAD, 1'b0, exec_pkg::MODE_POSTDEC, 1'b1, 1'b0, 8'h0, 7'h0));
      expect_reg(exec_pkg::PTR1_OFS, 32'hffff);
      // Relative offsets at both limits leave the pointer alone
      mem_set(8'h7f, 8'hc3);
      put(exec_pkg::PTR0_OFS, 32'h60);
      exec(mk(exec_pkg::OP_ILOAD, 1'b0, 2'h0, 1'b0, 1'b1, 8'h20, 7'h0));
      expect_reg(exec_pkg::WREG_OFS, 32'h81);
      exec(mk(exec_pkg::OP_ILOAD, 1'b0, 2'h0, 1'b0, 1'b1, 8'h1f, 7'h0));
      expect_reg(exec_pkg::WREG_OFS, 32'hc3);
      expect_reg(exec_pkg::PTR0_OFS, 32'h60);
      // A file move from the second indirect port reads where its pointer points
      mem_set(8'h43, 8'h9c);
      put(exec_pkg::PTR1_OFS, 32'h43);
      exec(mk(exec_pkg::OP_FMOVE, 1'b0, 2'h0, 1'b0, 1'b0, 8'h0, exec_pkg::IND1_FADDR));
      expect_reg(exec_pkg::WREG_OFS, 32'h9c);
      expect_reg(exec_pkg::PTR1_OFS, 32'h43);
      // A right shift written back through the first indirect port lands where its pointer points
      put(exec_pkg::PTR0_OFS, 32'h43);
      exec(mk(exec_pkg::OP_LSR, 1'b1, 2'h0, 1'b0, 1'b0, 8'h0, exec_pkg::IND0_FADDR));
      exec(mk(exec_pkg::OP_FMOVE, 1'b0, 2'h0, 1'b0, 1'b0, 8'h0, 7'h43));
      expect_reg(exec_pkg::WREG_OFS, 32'h4e);
      expect_reg(exec_pkg::PTR0_OFS, 32'h43);
      results();
   end
endmodule : shift_move_literal_exec_tb_top
